//--- rtl/rrc_core.v
// Operation
// R1 - basic mode: receive-on command from off or synth
// R2 - extended mode: auto-ack receive command likewise
// R3 - basic mode: rx-start and frame-end events
// R4 - link quality computed, appended to frame
// R5 - after frame update energy level, checksum bit
// R6 - frequency offset estimate corrects rest of frame
// R7 - nonzero level ignores rssi below floor+3(l-1)
// R8 - level zero receives every valid frame
// R9 - detect-disable blocks new frames, not ongoing
// R10 - detect-disable holds receive state until cleared
// R11 - protection holds frame until host reads it
// R12 - host ends frame read by raising select
// R13 - only checksum-valid frames get protected
// R14 - transmit starts by pin edge or command
// R15 - modulation begins 16 us after trigger
// R16 - amp buffer enabled first, then amplifier
// R17 - baseband reads buffer, maps bits to chips
// R18 - tx power register: lead times, power level
// R19 - sensitivity register layout, all reset zero
// R20 - buffer lead time 0,2,4,6 us
// R21 - amplifier lead time 2,4,6,8 us
// R22 - transmit pin synchronised, one edge per start
// R23 - reserved sensitivity bits read zero
`timescale 1ns/1ps
`include "rrc_map.vh"
module rrc_core
#(
  parameter AW = 8 // bus address width
)
(
  input  wire          core_clk,           // 125 MHz clock
  input  wire          rst_b,              // sync reset, active low
  input  wire          ce,                 // clock enable
  input  wire [AW-1:0] s_axi_awaddr,       // write address
  input  wire          s_axi_awvalid,      // write address valid
  output reg           s_axi_awready,      // write address ready
  input  wire [31:0]   s_axi_wdata,        // write data
  input  wire [3:0]    s_axi_wstrb,        // byte enables
  input  wire          s_axi_wvalid,       // write data valid
  output reg           s_axi_wready,       // write data ready
  output reg  [1:0]    s_axi_bresp,        // write response
  output reg           s_axi_bvalid,       // write response valid
  input  wire          s_axi_bready,       // write response ready
  input  wire [AW-1:0] s_axi_araddr,       // read address
  input  wire          s_axi_arvalid,      // read address valid
  output reg           s_axi_arready,      // read address ready
  output reg  [31:0]   s_axi_rdata,        // read data
  output reg  [1:0]    s_axi_rresp,        // read response
  output reg           s_axi_rvalid,       // read data valid
  input  wire          s_axi_rready,       // read data ready
  input  wire          sleep_transmit_pin, // transmit trigger pin
  input  wire          spi_sel_b,          // host chip select pin
  input  wire          spi_frame_rd,       // frame read mode active
  input  wire          rx_sync_det,        // sync header seen
  input  wire [6:0]    rx_rssi,            // dB above rssi floor
  input  wire [7:0]    rx_freq_est,        // offset estimate
  input  wire          rx_sym_valid,       // symbol decoded
  input  wire [7:0]    rx_sym_corr,        // symbol correlation
  input  wire          rx_done,            // frame received
  input  wire          rx_crc_ok,          // checksum good
  input  wire [7:0]    rx_ed,              // energy measured
  input  wire [7:0]    fb_rd_data,         // buffer read data
  input  wire          tx_chip_tick,       // chip period strobe
  output reg           rx_demod_en,        // demodulator running
  output reg  [7:0]    rx_freq_corr,       // correction applied
  output reg           rx_start_irq,       // rx start pulse
  output reg           frame_end_irq,      // frame end pulse
  output reg           lqi_wr,             // append quality byte
  output reg  [7:0]    lqi_data,           // quality byte
  output reg           rx_protected,       // buffer held
  output wire          fb_rd_en,           // buffer read strobe
  output wire [6:0]    fb_rd_addr,         // buffer read address
  output wire          tx_chip,            // chip out
  output wire          tx_chip_valid,      // chip out valid
  output reg           amp_buf_en,         // amplifier buffer on
  output reg           amp_en,             // amplifier on
  output reg           tx_mod_start,       // modulation start pulse
  output reg  [3:0]    output_power        // power level to amp
);
  localparam ST_OFF     = `RRC_ST_OFF;
  localparam ST_PLL     = `RRC_ST_PLL;
  localparam ST_RXON    = `RRC_ST_RXON;
  localparam ST_AACK    = `RRC_ST_AACK;
  localparam ST_ARET    = `RRC_ST_ARET;
  localparam ST_BUSY_RX = `RRC_ST_BUSY_RX;
  localparam ST_BUSY_TX = `RRC_ST_BUSY_TX;
  localparam integer STEP_CYC = `RRC_LT_STEP_NS / `RRC_CLK_NS;
  localparam integer DLY_CYC  = `RRC_TX_DELAY_NS / `RRC_CLK_NS;
  localparam [10:0] STEP11 = STEP_CYC[10:0];
  localparam [10:0] DLY11  = DLY_CYC[10:0];
  localparam [7:0]  SYN_RST = `RRC_SYN_RST;

  reg  [7:0]  tx_power_ramp_control;   // R18
  reg         preamble_detect_disable; // R19
  reg  [3:0]  sensitivity_threshold_level;
  reg         rx_safe;
  reg  [7:0]  energy_level;
  reg         crc_valid;
  reg  [6:0]  rssi_last;
  reg  [4:0]  state;
  reg         ext;
  reg         cmd_v;
  reg  [4:0]  cmd;
  reg  [10:0] tx_cnt;
  reg         pin_s1, pin_s2, pin_s3;
  reg         sel_s1, sel_s2, sel_s3;
  reg         rd_seen;
  reg         aw_hold, w_hold;
  reg  [5:0]  aw_idx;
  reg  [7:0]  w_byte;
  reg         w_lane;
  reg  [31:0] rd_word;
  wire        map_done;
  wire [7:0]  lqi_val;
  wire        pin_rise = pin_s2 & ~pin_s3; // R22
  wire        sel_rise = sel_s2 & ~sel_s3;
  wire        idle = (state != ST_BUSY_RX) && (state != ST_BUSY_TX);
  wire [1:0]  buf_lt = tx_power_ramp_control[7:6];
  wire [1:0]  amp_lead_time  = tx_power_ramp_control[5:4];
  // frames below this many dB above the floor are dropped
  wire [6:0]  thres = {3'b000, sensitivity_threshold_level - 4'h1}
                      * `RRC_THRES_STEP; // R7
  wire        lvl_ok = (sensitivity_threshold_level == 4'h0) // R8
                       || (rx_rssi >= thres); // R7
  wire        rx_ok = rx_sync_det && !preamble_detect_disable // R9 R10
                      && !rx_protected && lvl_ok; // R11
  wire        tx_trig = (state == ST_PLL || state == ST_ARET)
                        && (pin_rise || (cmd_v
                        && cmd == `RRC_CMD_TX_START)); // R14
  wire [10:0] pa_on  = DLY11 - lead_cyc({1'b0, amp_lead_time} + 3'd1); // R21
  wire [10:0] buf_on = pa_on - lead_cyc({1'b0, buf_lt}); // R20
  wire        do_wr  = aw_hold && w_hold && !s_axi_bvalid;
  wire [5:0]  ar_idx = s_axi_araddr[7:2];

  // lead time in cycles for a count of 2 us steps
  function [10:0] lead_cyc;
    input [2:0] n;
    begin
      lead_cyc = STEP11 * {8'h00, n};
    end
  endfunction

  // which word indices answer on the bus
  function idx_ok;
    input [5:0] i;
    begin
      idx_ok = (i == `RRC_IDX_STATE) || (i == `RRC_IDX_TXPWR) ||
               (i == `RRC_IDX_RSSI)  || (i == `RRC_IDX_ED)    ||
               (i == `RRC_IDX_CTRL2) || (i == `RRC_IDX_SYN);
    end
  endfunction

  rrc_lqi u_lqi
  (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .clr       (rx_ok & ~rx_demod_en),
    .sym_valid (rx_sym_valid & rx_demod_en),
    .sym_corr  (rx_sym_corr),
    .lqi       (lqi_val)
  );

  rrc_tx_mapper u_map
  (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .ce         (ce),
    .start      (tx_mod_start),
    .chip_tick  (tx_chip_tick),
    .fb_rd_data (fb_rd_data),
    .fb_rd_en   (fb_rd_en),
    .fb_rd_addr (fb_rd_addr),
    .chip       (tx_chip),
    .chip_valid (tx_chip_valid),
    .done       (map_done)
  );

  // two flops on each pin before any logic looks at it
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      {pin_s1, pin_s2, pin_s3} <= 3'b000;
      {sel_s1, sel_s2, sel_s3} <= 3'b111;
    end
    else if (ce)
    begin
      {pin_s1, pin_s2, pin_s3} <= {sleep_transmit_pin, pin_s1, pin_s2};
      {sel_s1, sel_s2, sel_s3} <= {spi_sel_b, sel_s1, sel_s2};
    end
  end

  // read mux; reserved bits and unmapped words read zero
  always @*
  begin
    rd_word = 32'h0000_0000;
    case (ar_idx)
      `RRC_IDX_STATE: rd_word[4:0] = state;
      `RRC_IDX_TXPWR: rd_word[7:0] = tx_power_ramp_control;
      `RRC_IDX_RSSI:  rd_word[7:0] = {crc_valid, rssi_last};
      `RRC_IDX_ED:    rd_word[7:0] = energy_level;
      `RRC_IDX_CTRL2: rd_word[`RRC_SAFE_BIT] = rx_safe;
      `RRC_IDX_SYN:   rd_word[7:0] = {preamble_detect_disable, 3'b000,
                                      sensitivity_threshold_level}; // R23
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  // bus slave: address and data taken in either order, one each
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RRC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RRC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_idx  <= 6'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx <= s_axi_awaddr[7:2];
        aw_hold <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
        w_hold <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= idx_ok(aw_idx) ? `RRC_RESP_OKAY
                                      : `RRC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= idx_ok(ar_idx) ? `RRC_RESP_OKAY
                                      : `RRC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // software registers; a command write becomes a one-cycle request
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      tx_power_ramp_control <= `RRC_TXPWR_RST;
      {preamble_detect_disable, sensitivity_threshold_level} <=
        {SYN_RST[`RRC_SYN_DIS_BIT], SYN_RST[3:0]}; // R19
      rx_safe <= 1'b0;
      cmd_v <= 1'b0;
      cmd <= 5'h00;
      output_power <= 4'h0;
    end
    else if (ce)
    begin
      cmd_v <= 1'b0;
      output_power <= tx_power_ramp_control[3:0]; // R18
      if (do_wr && w_lane)
      begin
        case (aw_idx)
          `RRC_IDX_STATE:
          begin
            cmd_v <= 1'b1;
            cmd <= w_byte[`RRC_CMD_MSB:0];
          end
          `RRC_IDX_TXPWR: tx_power_ramp_control <= w_byte; // R18
          `RRC_IDX_CTRL2: rx_safe <= w_byte[`RRC_SAFE_BIT];
          `RRC_IDX_SYN:
          begin
            // bits 6:4 are not stored, so writes there vanish
            preamble_detect_disable <= w_byte[`RRC_SYN_DIS_BIT]; // R23
            sensitivity_threshold_level <= w_byte[3:0];
          end
          default: cmd_v <= 1'b0;
        endcase
      end
    end
  end

  // buffer protection: set by a good frame, freed when the host
  // has read it and raised select; a set in the same cycle wins
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rx_protected <= 1'b0;
      rd_seen <= 1'b0;
    end
    else if (ce)
    begin
      if (state == ST_BUSY_RX && rx_done && rx_safe && rx_crc_ok)
      begin
        rx_protected <= 1'b1; // R11 R13
        rd_seen <= 1'b0;
      end
      else if (rd_seen && sel_rise)
      begin
        rx_protected <= 1'b0; // R12
        rd_seen <= 1'b0;
      end
      else if (rx_protected && spi_frame_rd && !sel_s2)
        rd_seen <= 1'b1;
    end
  end

  // transceiver state machine
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state <= ST_OFF;
      ext <= 1'b0;
      tx_cnt <= 11'h000;
      rx_demod_en <= 1'b0;
      rx_freq_corr <= 8'h00;
      rx_start_irq <= 1'b0;
      frame_end_irq <= 1'b0;
      lqi_wr <= 1'b0;
      lqi_data <= 8'h00;
      energy_level <= 8'h00;
      crc_valid <= 1'b0;
      rssi_last <= 7'h00;
      amp_buf_en <= 1'b0;
      amp_en <= 1'b0;
      tx_mod_start <= 1'b0;
    end
    else if (ce)
    begin
      rx_start_irq <= 1'b0;
      frame_end_irq <= 1'b0;
      lqi_wr <= 1'b0;
      tx_mod_start <= 1'b0;
      if (tx_trig)
      begin
        ext <= (state == ST_ARET);
        tx_cnt <= 11'h000;
        state <= ST_BUSY_TX; // R14
      end
      else if ((state == ST_RXON || state == ST_AACK) && rx_ok)
      begin
        ext <= (state == ST_AACK);
        rx_start_irq <= (state == ST_RXON); // R3
        rx_freq_corr <= rx_freq_est; // R6
        rssi_last <= rx_rssi;
        rx_demod_en <= 1'b1;
        state <= ST_BUSY_RX;
      end
      else if (idle && cmd_v)
      begin
        case (cmd)
          `RRC_CMD_RX_ON:
            if (state == ST_OFF || state == ST_PLL)
              state <= ST_RXON; // R1
          `RRC_CMD_AACK_ON:
            if (state == ST_OFF || state == ST_PLL)
              state <= ST_AACK; // R2
          `RRC_CMD_PLL_ON:  state <= ST_PLL;
          `RRC_CMD_TRANSCEIVER_OFF_STATE: state <= ST_OFF;
          `RRC_CMD_ARET_ON: state <= ST_ARET;
          default:          state <= state;
        endcase
      end
      else if (state == ST_BUSY_RX && rx_done)
      begin
        rx_demod_en <= 1'b0;
        frame_end_irq <= ~ext; // R3
        lqi_wr <= 1'b1; // R4
        lqi_data <= lqi_val;
        energy_level <= rx_ed; // R5
        crc_valid <= rx_crc_ok; // R5
        state <= ext ? ST_AACK : ST_RXON;
      end
      else if (state == ST_BUSY_TX)
      begin
        if (tx_cnt != DLY11)
          tx_cnt <= tx_cnt + 11'h001;
        amp_buf_en <= (tx_cnt >= buf_on - 11'h001); // R16 R20
        amp_en <= (tx_cnt >= pa_on - 11'h001); // R16 R21
        tx_mod_start <= (tx_cnt == DLY11 - 11'h001); // R15
        if (map_done)
        begin
          amp_buf_en <= 1'b0;
          amp_en <= 1'b0;
          frame_end_irq <= ~ext;
          state <= ext ? ST_ARET : ST_PLL;
        end
      end
    end
  end
endmodule // rrc_core

//--- pkg/rrc_map.vh
`ifndef RRC_MAP_VH
`define RRC_MAP_VH
// register indices; byte address is four times the index
`define RRC_IDX_STATE   6'h02
`define RRC_IDX_TXPWR   6'h05
`define RRC_IDX_RSSI    6'h06
`define RRC_IDX_ED      6'h07
`define RRC_IDX_CTRL2   6'h0c
`define RRC_IDX_SYN     6'h15
// reset values and field positions
`define RRC_TXPWR_RST   8'hc0
`define RRC_SYN_RST     8'h00
`define RRC_SYN_DIS_BIT 7
`define RRC_SAFE_BIT    7
`define RRC_CRC_BIT     7
`define RRC_CMD_MSB     4
// transceiver states, read back in the state register
`define RRC_ST_OFF      5'h01
`define RRC_ST_PLL      5'h02
`define RRC_ST_RXON     5'h03
`define RRC_ST_AACK     5'h04
`define RRC_ST_ARET     5'h05
`define RRC_ST_BUSY_RX  5'h06
`define RRC_ST_BUSY_TX  5'h07
// commands written to the command field
`define RRC_CMD_TX_START 5'h01
`define RRC_CMD_RX_ON    5'h02
`define RRC_CMD_TRANSCEIVER_OFF_STATE  5'h03
`define RRC_CMD_PLL_ON   5'h04
`define RRC_CMD_AACK_ON  5'h05
`define RRC_CMD_ARET_ON  5'h06
// timing
`define RRC_CLK_NS      8
`define RRC_LT_STEP_NS  2000
`define RRC_TX_DELAY_NS 16000
`define RRC_THRES_STEP  7'd3
// bus answers
`define RRC_RESP_OKAY   2'b00
`define RRC_RESP_SLVERR 2'b10
// base chip sequence, chip 0 in bit 0, and odd-chip inversion mask
`define RRC_CHIP_SEQ0   32'h744ac39b
`define RRC_ODD_CHIPS   32'haaaaaaaa
`define RRC_LQI_SHIFT   3
`endif

//--- rtl/rrc_lqi.v
`timescale 1ns/1ps
`include "rrc_map.vh"
module rrc_lqi
(
  input  wire       core_clk,  // system clock
  input  wire       rst_b,     // sync reset, active low
  input  wire       ce,        // clock enable
  input  wire       clr,       // start of a new frame
  input  wire       sym_valid, // one symbol correlated
  input  wire [7:0] sym_corr,  // correlation of that symbol
  output reg  [7:0] lqi        // running link quality
);
  reg        seeded;
  wire [8:0] diff = {1'b0, sym_corr} - {1'b0, lqi};
  // arithmetic shift keeps the sign of the step
  wire [8:0] step = $signed(diff) >>> `RRC_LQI_SHIFT;

  // moving average over all symbols of the frame
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      lqi    <= 8'h00;
      seeded <= 1'b0;
    end
    else if (ce)
    begin
      if (clr)
      begin
        lqi    <= 8'h00;
        seeded <= 1'b0;
      end
      else if (sym_valid)
      begin
        seeded <= 1'b1;
        lqi    <= seeded ? lqi + step[7:0] : sym_corr; // R4
      end
    end
  end
endmodule // rrc_lqi

//--- rtl/rrc_tx_mapper.v
`timescale 1ns/1ps
`include "rrc_map.vh"
module rrc_tx_mapper
(
  input  wire       core_clk,   // system clock
  input  wire       rst_b,      // sync reset, active low
  input  wire       ce,         // clock enable
  input  wire       start,      // begin sending the buffered frame
  input  wire       chip_tick,  // one chip period elapsed
  input  wire [7:0] fb_rd_data, // buffer byte, one cycle after enable
  output reg        fb_rd_en,   // buffer read strobe
  output reg  [6:0] fb_rd_addr, // buffer read address
  output reg        chip,       // current chip
  output reg        chip_valid, // chip pulse
  output reg        done        // frame fully sent, pulse
);
  localparam M_IDLE = 2'd0;
  localparam M_REQ  = 2'd1;
  localparam M_LOAD = 2'd2;
  localparam M_SEND = 2'd3;
  reg [1:0] mst;
  reg [7:0] byte_q;
  reg [6:0] left;
  reg       first;
  reg       nib;
  reg [4:0] cidx;
  wire [3:0]  sym   = nib ? byte_q[7:4] : byte_q[3:0];
  wire [31:0] chips = chips_of(sym);

  // symbols 0..7 rotate the base sequence, 8..15 also flip odd chips
  function [31:0] chips_of;
    input [3:0] s;
    reg [63:0] r;
    begin
      r = {`RRC_CHIP_SEQ0, `RRC_CHIP_SEQ0} << {s[2:0], 2'b00};
      chips_of = s[3] ? r[63:32] ^ `RRC_ODD_CHIPS : r[63:32];
    end
  endfunction

  // fetch each byte, low nibble first, 32 chips per symbol
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      mst <= M_IDLE;
      fb_rd_en <= 1'b0;
      fb_rd_addr <= 7'h00;
      chip <= 1'b0;
      chip_valid <= 1'b0;
      done <= 1'b0;
      byte_q <= 8'h00;
      left <= 7'h00;
      first <= 1'b0;
      nib <= 1'b0;
      cidx <= 5'h00;
    end
    else if (ce)
    begin
      chip_valid <= 1'b0;
      done <= 1'b0;
      fb_rd_en <= 1'b0;
      case (mst)
        M_IDLE:
          if (start)
          begin
            fb_rd_addr <= 7'h00;
            first <= 1'b1;
            mst <= M_REQ;
          end
        M_REQ:
        begin
          fb_rd_en <= 1'b1; // R17
          mst <= M_LOAD;
        end
        M_LOAD:
          if (!fb_rd_en)
          begin
            byte_q <= fb_rd_data;
            if (first)
              left <= fb_rd_data[6:0]; // length byte leads the frame
            first <= 1'b0;
            nib <= 1'b0;
            cidx <= 5'h00;
            mst <= M_SEND;
          end
        M_SEND:
          if (chip_tick)
          begin
            chip <= chips[cidx]; // R17
            chip_valid <= 1'b1;
            cidx <= cidx + 5'h01;
            if (&cidx)
            begin
              nib <= ~nib;
              if (nib && left == 7'h00)
              begin
                done <= 1'b1;
                mst <= M_IDLE;
              end
              else if (nib)
              begin
                left <= left - 7'h01;
                fb_rd_addr <= fb_rd_addr + 7'h01;
                mst <= M_REQ;
              end
            end
          end
        default:
          mst <= M_IDLE;
      endcase
    end
  end
endmodule // rrc_tx_mapper

//--- sim/rrc_core_sva.sv
`timescale 1ns/1ps
module rrc_core_sva
(
  input wire       core_clk,      // system clock
  input wire       rst_b,         // sync reset, active low
  input wire       rx_sync_det,   // sync header seen
  input wire       rx_done,       // frame received
  input wire [7:0] rx_freq_est,   // offset estimate
  input wire       rx_demod_en,   // demodulator running
  input wire [7:0] rx_freq_corr,  // correction applied
  input wire       rx_start_irq,  // rx start pulse
  input wire       lqi_wr,        // quality byte strobe
  input wire       amp_buf_en,    // amplifier buffer on
  input wire       amp_en,        // amplifier on
  input wire       tx_mod_start,  // modulation start
  input wire       tx_chip_valid  // chip out valid
);
  // one domain, so clock and reset are given once for all
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_sync_start: assert property ($rose(rx_demod_en) |->
    $past(rx_sync_det))
    else $error("demod started without sync");
  chk_start_irq: assert property (rx_start_irq |-> $rose(rx_demod_en))
    else $error("start event without demod start");
  chk_freq_load: assert property ($rose(rx_demod_en) |->
    rx_freq_corr == $past(rx_freq_est))
    else $error("offset not loaded at accept");
  chk_freq_hold: assert property (rx_demod_en && $past(rx_demod_en) |->
    $stable(rx_freq_corr))
    else $error("offset changed inside frame");
  chk_done_end: assert property (rx_done && rx_demod_en |=>
    lqi_wr && !rx_demod_en)
    else $error("frame end without quality byte");
  chk_lqi_cause: assert property (lqi_wr |-> $past(rx_done))
    else $error("quality byte without frame end");
  chk_buf_first: assert property ($rose(amp_en) |-> amp_buf_en)
    else $error("amplifier before its buffer");
  // shortest amplifier lead is 2 us, 250 cycles
  chk_amp_lead: assert property (tx_mod_start |->
    amp_en && $past(amp_en, 250))
    else $error("amplifier lead too short");
  chk_chip_amp: assert property (tx_chip_valid |-> amp_en && amp_buf_en)
    else $error("chips sent with amplifier off");
endmodule // rrc_core_sva

//--- sim/rrc_fb_model.sv
`timescale 1ns/1ps
module rrc_fb_model
(
  input  wire       core_clk,    // system clock
  input  wire       fb_rd_en,    // buffer read strobe
  input  wire [6:0] fb_rd_addr,  // buffer read address
  output reg  [7:0] fb_rd_data,  // byte one cycle after strobe
  output reg        tx_chip_tick // chip period strobe
);
  initial fb_rd_data = 8'h00;
  initial tx_chip_tick = 1'b0;
  // a one-byte frame; between reads the data toggles so a sample
  // one cycle late reads the inverse, not the stored byte
  always @(posedge core_clk)
  begin
    tx_chip_tick <= ~tx_chip_tick;
    if (fb_rd_en)
      fb_rd_data <= (fb_rd_addr == 7'h00) ? 8'h01 : 8'ha5;
    else
      fb_rd_data <= ~fb_rd_data;
  end
endmodule // rrc_fb_model

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "rrc_map.vh"
module tb_top;
  logic        core_clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0;
  logic        rry = 0, pin = 0, sel_b = 1, frd = 0, sync = 0, done = 0;
  logic        crc = 0, awr, wrd, bv, arr, rv, dmd, sirq, eirq, lqw, prot;
  logic        fen, tick, chip, chv, abuf, amp, mods, pab = 0, pam = 0;
  logic [7:0]  awa = 0, ara = 0, fest = 0, ed = 0, fcr, lqd, fdat;
  logic [31:0] wd = 0, rdat;
  logic [6:0]  rssi = 0, fadr;
  logic [1:0]  bresp, rresp;
  logic [3:0]  pwr;
  int          failures = 0, checks_done = 0, cyc = 0, tb0, ta, tm, tp;

  always #4 core_clk = ~core_clk;

  rrc_core rrc_core_i (.core_clk(core_clk), .rst_b(rst_b), .ce(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .sleep_transmit_pin(pin),
    .spi_sel_b(sel_b), .spi_frame_rd(frd), .rx_sync_det(sync),
    .rx_rssi(rssi), .rx_freq_est(fest), .rx_sym_valid(dmd),
    .rx_sym_corr({1'b0, rssi}), .rx_done(done), .rx_crc_ok(crc), .rx_ed(ed),
    .fb_rd_data(fdat), .tx_chip_tick(tick), .rx_demod_en(dmd),
    .rx_freq_corr(fcr), .rx_start_irq(sirq), .frame_end_irq(eirq),
    .lqi_wr(lqw), .lqi_data(lqd), .rx_protected(prot), .fb_rd_en(fen),
    .fb_rd_addr(fadr), .tx_chip(chip), .tx_chip_valid(chv),
    .amp_buf_en(abuf), .amp_en(amp), .tx_mod_start(mods),
    .output_power(pwr));
  rrc_fb_model rrc_fb_model_i (.core_clk(core_clk), .fb_rd_en(fen),
    .fb_rd_addr(fadr), .fb_rd_data(fdat), .tx_chip_tick(tick));

  // cycle count, ramp stamps and the hang limit
  always @(posedge core_clk)
  begin
    cyc++;
    if (abuf && !pab) tb0 = cyc;
    if (amp && !pam) ta = cyc;
    if (mods) tm = cyc;
    pab = abuf;
    pam = amp;
    if (cyc == 40000)
    begin
      failures++;
      summarize;
    end
  end

  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask

  // a spare edge at the end keeps two calls from driving one step
  task wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do
    begin
      @(posedge core_clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (!bv);
    bry <= 0;
    @(posedge core_clk);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do
    begin
      @(posedge core_clk);
      if (arr) arv <= 0;
    end while (!rv);
    cmp(rdat, e);
    cmp(rresp, r);
    rry <= 0;
    @(posedge core_clk);
  endtask

  // offer a sync header; if taken, end it and read back its status
  task frm(input logic [6:0] r, input logic c, e, s);
    sync <= 1;
    rssi <= r;
    fest <= fest + 8'h11;
    @(posedge core_clk);
    sync <= 0;
    @(posedge core_clk);
    cmp(dmd, e);
    cmp(sirq, s);
    if (e)
    begin
      done <= 1;
      crc <= c;
      ed <= {1'b0, r} + 8'h20;
      @(posedge core_clk);
      done <= 0;
      @(posedge core_clk);
      cmp(lqw, 1);
      cmp(lqd, {1'b0, r});
      cmp(eirq, s);
      rc(8'h1c, {1'b0, r} + 8'h20, 0);
      rc(8'h18, {c, r}, 0);
    end
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1;
    @(posedge core_clk);
    rc(8'h14, 8'hc0, 0);
    rc(8'h54, 8'h00, 0);
    wr(8'h54, 8'hff);
    rc(8'h54, 8'h8f, 0);
    rc(8'h04, 0, `RRC_RESP_SLVERR);
    wr(8'h54, 8'h00);
    wr(8'h08, `RRC_CMD_RX_ON);
    rc(8'h08, `RRC_ST_RXON, 0);
    $display("test registers done");
    frm(7'd0, 1, 1, 1);
    wr(8'h54, 8'h03);
    frm(7'd5, 1, 0, 0);
    frm(7'd6, 1, 1, 1);
    wr(8'h54, 8'h80);
    frm(7'd90, 1, 0, 0);
    rc(8'h08, `RRC_ST_RXON, 0);
    wr(8'h54, 8'h00);
    $display("test threshold done");
    wr(8'h30, 8'h80);
    frm(7'd10, 0, 1, 1);
    cmp(prot, 0);
    frm(7'd10, 1, 1, 1);
    cmp(prot, 1);
    frm(7'd10, 1, 0, 0);
    sel_b <= 0;
    frd <= 1;
    repeat (4) @(posedge core_clk);
    sel_b <= 1;
    frd <= 0;
    repeat (8) @(posedge core_clk);
    cmp(prot, 0);
    $display("test protection done");
    wr(8'h08, `RRC_CMD_TRANSCEIVER_OFF_STATE);
    wr(8'h08, `RRC_CMD_AACK_ON);
    rc(8'h08, `RRC_ST_AACK, 0);
    wr(8'h08, `RRC_CMD_TRANSCEIVER_OFF_STATE);
    wr(8'h08, `RRC_CMD_PLL_ON);
    pin <= 1;
    tp = cyc;
    @(posedge core_clk iff eirq);
    cmp(tm - tp >= 2000 && tm - tp <= 2005, 1);
    cmp(ta - tb0, 750);
    cmp(tm - ta, 250);
    rc(8'h08, `RRC_ST_PLL, 0);
    pin <= 0;
    wr(8'h14, 8'h35);
    cmp(pwr, 4'h5);
    wr(8'h08, `RRC_CMD_TX_START);
    @(posedge core_clk iff eirq);
    cmp(ta - tb0, 0);
    cmp(tm - ta, 1000);
    wr(8'h08, `RRC_CMD_ARET_ON);
    wr(8'h08, `RRC_CMD_TX_START);
    rc(8'h08, `RRC_ST_BUSY_TX, 0);
    $display("test transmit done");
    summarize;
  end
endmodule // tb_top

bind rrc_core rrc_core_sva rrc_core_sva_i (.core_clk(core_clk),
  .rst_b(rst_b), .rx_sync_det(rx_sync_det), .rx_done(rx_done),
  .rx_freq_est(rx_freq_est), .rx_demod_en(rx_demod_en),
  .rx_freq_corr(rx_freq_corr), .rx_start_irq(rx_start_irq),
  .lqi_wr(lqi_wr), .amp_buf_en(amp_buf_en), .amp_en(amp_en),
  .tx_mod_start(tx_mod_start), .tx_chip_valid(tx_chip_valid));
